// ---- hdl/nand_host_consts.svh ----
// constants for the nand flash host controller
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH
`define CMD_READ_A        8'h00
`define CMD_READ_B        8'h01
`define CMD_READ_SPARE    8'h50
`define CMD_IDENTIFICATION_READ_CMD       8'h90
`define CMD_RESET         8'hFF
`define CMD_STATUS        8'h70
`define CMD_PROG_SETUP    8'h80
`define CMD_PROG_EXEC     8'h10
`define CMD_COPY_EXEC     8'h8A
`define CMD_ERASE_SETUP   8'h60
`define CMD_ERASE_EXEC    8'hD0
`define PAGE_BYTES_X8     10'd528
`define PAGE_WORDS_X16    10'd264
`define SPARE_START_X8    10'd512
`define SPARE_START_X16   10'd256
`define NUM_BLOCKS        12'd2048
`define ADDR_BITS         24
`define STROBE_LOW_CYC    2'd2
`define STROBE_HIGH_CYC   2'd1
`endif

// ---- hdl/nand_host_pkg.sv ----
// types for the nand flash host controller
package nand_host_pkg;
  typedef enum logic [2:0]
  {
    OP_NONE    = 3'b000,
    OP_READ    = 3'b001,
    OP_IDENTIFICATION_READ_CMD = 3'b010,
    OP_RESET   = 3'b011,
    OP_STATUS  = 3'b100,
    OP_PROGRAM = 3'b101,
    OP_COPY    = 3'b110,
    OP_ERASE   = 3'b111
  } op_t;

  typedef enum logic [1:0]
  {
    AREA_FIRST  = 2'b00,
    AREA_SECOND = 2'b01,
    AREA_SPARE  = 2'b10
  } area_t;

  typedef enum logic [1:0]
  {
    CYC_CMD  = 2'b00,
    CYC_ADDR = 2'b01,
    CYC_WDAT = 2'b10,
    CYC_RDAT = 2'b11
  } cyc_t;
endpackage : nand_host_pkg

// ---- hdl/nand_bus_cycle.sv ----
// one strobed bus cycle on the nand pins: write or read
`timescale 1ns/1ps
`include "nand_host_consts.svh"
module nand_bus_cycle
#(
  parameter int DW = 16
)
(
  input  wire logic              clk,        // system clock
  input  wire logic              nrst,       // async reset, low
  input  wire logic              start,      // begin one cycle
  input  wire nand_host_pkg::cyc_t kind,     // command, address or data
  input  wire logic [DW-1:0]     wdata,      // value to drive
  input  wire logic [DW-1:0]     io_sync,    // synchronised io inputs
  output logic                   busy,       // cycle in progress
  output logic                   done,       // one-cycle pulse at end
  output logic [DW-1:0]          rdata,      // captured read value
  output logic                   cle,        // command latch strobe
  output logic                   ale,        // address latch strobe
  output logic                   write_n,    // write strobe, low active
  output logic                   read_strobe_n, // read strobe, low active
  output logic [DW-1:0]          io_out,     // io drive value
  output logic                   io_oe_n     // io drive enable, low
);
  import nand_host_pkg::*;

  // ------------------------------------------------------------
  // strobe sequencing
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    B_IDLE = 2'b00,
    B_LOW  = 2'b01,
    B_HIGH = 2'b10
  } bst_t;

  bst_t          st_r, st_nxt;
  logic [1:0]    cnt_r, cnt_nxt;
  cyc_t          kind_r, kind_nxt;
  logic [DW-1:0] wd_r, wd_nxt;
  logic [DW-1:0] rd_r, rd_nxt;
  logic          done_nxt;

  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    kind_nxt = kind_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    done_nxt = 1'b0;
    unique case (st_r)
      B_IDLE:
      begin
        if (start)
        begin
          st_nxt   = B_LOW;
          cnt_nxt  = `STROBE_LOW_CYC;
          kind_nxt = kind;
          wd_nxt   = wdata;
        end
      end
      B_LOW:
      begin
        if (cnt_r == 2'd0)
        begin
          // the synchroniser delays io by two cycles; the strobe low time covers it
          if (kind_r == CYC_RDAT)
            rd_nxt = io_sync;
          st_nxt  = B_HIGH;
          cnt_nxt = `STROBE_HIGH_CYC;
        end
        else
          cnt_nxt = cnt_r - 2'd1;
      end
      B_HIGH:
      begin
        if (cnt_r == 2'd0)
        begin
          st_nxt   = B_IDLE;
          done_nxt = 1'b1;
        end
        else
          cnt_nxt = cnt_r - 2'd1;
      end
      default: st_nxt = B_IDLE;
    endcase
  end

  logic done_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r   <= B_IDLE;
      cnt_r  <= 2'd0;
      kind_r <= CYC_CMD;
      wd_r   <= '0;
      rd_r   <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      kind_r <= kind_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy          = (st_r != B_IDLE);
  assign done          = done_r;
  assign rdata         = rd_r;
  assign cle           = busy && (kind_r == CYC_CMD);
  assign ale           = busy && (kind_r == CYC_ADDR);
  assign write_n       = !((st_r == B_LOW) && (kind_r != CYC_RDAT));
  assign read_strobe_n = !((st_r == B_LOW) && (kind_r == CYC_RDAT));
  assign io_out        = wd_r;
  assign io_oe_n       = !(busy && (kind_r != CYC_RDAT));
endmodule : nand_bus_cycle

// ---- hdl/nand_host.sv ----
// host controller that drives a nand flash through its pins
// Functional notes
// - spare select low includes spare, high skips
// - x16 address on low lines, upper low
// - write strobe low with chip enable low
// - cle marks command, ale marks address
// - one-cycle commands, or setup then execute
// - address: column, low row, high row
// - read and program take three address cycles
// - erase takes only two row cycles
// - only reset or status while busy
// - never issue undefined command codes
`timescale 1ns/1ps
`include "nand_host_consts.svh"
module nand_host
#(
  parameter int  DW      = 16,   // 8 for x8 part, 16 for x16 part
  parameter int  NWORDS  = 264   // words per transfer when spare included
)
(
  input  wire logic                  clk,           // 10 MHz clock
  input  wire logic                  nrst,          // async reset, low
  input  wire logic                  req_valid,     // operation request
  output logic                       req_ready,     // controller idle
  input  wire nand_host_pkg::op_t    req_op,        // operation kind
  input  wire nand_host_pkg::area_t  req_area,      // read area select
  input  wire logic [23:0]           req_addr,      // column, row address
  input  wire logic [9:0]            req_len,       // data words to move
  input  wire logic                  wr_valid,      // program data valid
  output logic                       wr_ready,      // program data taken
  input  wire logic [DW-1:0]         wr_data,       // program data
  output logic                       rd_valid,      // read data pulse
  output logic [DW-1:0]              rd_data,       // read data
  output logic                       op_done,       // one-cycle end pulse
  input  wire logic                  spare_skip,    // level for spare select pin
  output logic                       spare_sel,     // spare select pin drive
  output logic                       chip_en_n,     // chip enable, low
  output logic                       cle,           // command latch strobe
  output logic                       ale,           // address latch strobe
  output logic                       write_n,       // write strobe, low
  output logic                       read_strobe_n, // read strobe, low
  output logic                       write_prot_n,  // write protect, low
  input  wire logic [DW-1:0]         io_in,         // io pins, as seen
  output logic [DW-1:0]              io_out,        // io drive value
  output logic                       io_oe_n,       // io drive enable, low
  input  wire logic                  ready_pin      // open-drain ready line
);
  import nand_host_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [DW-1:0] io_s1_r, io_s2_r;
  logic          rdy_s1_r, rdy_s2_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      io_s1_r  <= '0;
      io_s2_r  <= '0;
      rdy_s1_r <= 1'b1;
      rdy_s2_r <= 1'b1;
    end
    else
    begin
      io_s1_r  <= io_in;
      io_s2_r  <= io_s1_r;
      rdy_s1_r <= ready_pin;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    S_IDLE  = 3'b000,
    S_CMD1  = 3'b001,
    S_ADDR  = 3'b010,
    S_WDATA = 3'b011,
    S_CMD2  = 3'b100,
    S_WAIT  = 3'b101,
    S_RDATA = 3'b110,
    S_BUSY0 = 3'b111
  } st_t;

  st_t         st_r, st_nxt;
  op_t         op_r, op_nxt;
  area_t       area_r, area_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [1:0]  acnt_r, acnt_nxt;
  logic [9:0]  dcnt_r, dcnt_nxt;
  logic        ce_r, ce_nxt;
  logic        done_r, done_nxt;
  logic        rdv_r, rdv_nxt;

  logic          cyc_start;
  cyc_t          cyc_kind;
  logic [DW-1:0] cyc_wdata;
  logic          cyc_busy, cyc_done;
  logic [DW-1:0] cyc_rdata;

  // first command byte from operation and area
  function automatic logic [7:0] first_cmd(input op_t op, input area_t ar);
    logic [7:0] c;
    c = `CMD_STATUS;
    unique case (op)
      OP_READ, OP_COPY:
        if (ar == AREA_SPARE)
          c = `CMD_READ_SPARE;
        else if (ar == AREA_SECOND && DW == 8)
          c = `CMD_READ_B;
        else
          c = `CMD_READ_A;
      OP_IDENTIFICATION_READ_CMD: c = `CMD_IDENTIFICATION_READ_CMD;
      OP_RESET:   c = `CMD_RESET;
      OP_STATUS:  c = `CMD_STATUS;
      OP_PROGRAM: c = `CMD_PROG_SETUP;
      OP_ERASE:   c = `CMD_ERASE_SETUP;
      default:    c = `CMD_STATUS;
    endcase
    return c;
  endfunction : first_cmd

  function automatic logic [7:0] second_cmd(input op_t op);
    logic [7:0] c;
    c = `CMD_PROG_EXEC;
    if (op == OP_COPY)
      c = `CMD_COPY_EXEC;
    else if (op == OP_ERASE)
      c = `CMD_ERASE_EXEC;
    return c;
  endfunction : second_cmd

  logic two_step;
  assign two_step = (op_r == OP_PROGRAM) || (op_r == OP_COPY) || (op_r == OP_ERASE);

  always_comb
  begin
    st_nxt    = st_r;
    op_nxt    = op_r;
    area_nxt  = area_r;
    addr_nxt  = addr_r;
    acnt_nxt  = acnt_r;
    dcnt_nxt  = dcnt_r;
    ce_nxt    = ce_r;
    done_nxt  = 1'b0;
    rdv_nxt   = 1'b0;
    cyc_start = 1'b0;
    cyc_kind  = CYC_CMD;
    cyc_wdata = '0;
    wr_ready  = 1'b0;
    unique case (st_r)
      S_IDLE:
      begin
        // only reset or status may go out while the device is busy
        if (req_valid && (rdy_s2_r || req_op == OP_RESET || req_op == OP_STATUS))
        begin
          op_nxt   = req_op;
          area_nxt = req_area;
          addr_nxt = req_addr;
          dcnt_nxt = req_len;
          ce_nxt   = 1'b1;
          st_nxt   = S_CMD1;
        end
      end
      S_CMD1:
      begin
        cyc_start = !cyc_busy;
        cyc_kind  = CYC_CMD;
        cyc_wdata = DW'(first_cmd(op_r, area_r));
        if (cyc_done)
        begin
          // erase skips the column byte
          acnt_nxt = (op_r == OP_ERASE) ? 2'd1 : 2'd0;
          if (op_r == OP_READ || op_r == OP_PROGRAM || op_r == OP_COPY ||
              op_r == OP_ERASE || op_r == OP_IDENTIFICATION_READ_CMD)
            st_nxt = S_ADDR;
          else if (op_r == OP_STATUS)
            st_nxt = S_RDATA;
          else
            st_nxt = S_BUSY0;
        end
      end
      S_ADDR:
      begin
        cyc_start = !cyc_busy;
        cyc_kind  = CYC_ADDR;
        unique case (acnt_r)
          2'd0:    cyc_wdata = DW'(addr_r[7:0]);
          2'd1:    cyc_wdata = DW'(addr_r[15:8]);
          default: cyc_wdata = DW'(addr_r[23:16]);
        endcase
        if (cyc_done)
        begin
          // identification_read_cmd sends one address byte; never more than needed
          if (acnt_r == 2'd2 || op_r == OP_IDENTIFICATION_READ_CMD)
          begin
            if (op_r == OP_PROGRAM)
              st_nxt = S_WDATA;
            else if (op_r == OP_IDENTIFICATION_READ_CMD)
              st_nxt = S_RDATA;
            else if (op_r == OP_ERASE)
              st_nxt = S_CMD2;
            else if (op_r == OP_COPY)
              st_nxt = S_BUSY0;
            else
              st_nxt = S_WAIT;
          end
          acnt_nxt = acnt_r + 2'd1;
        end
      end
      S_WDATA:
      begin
        if (dcnt_r == 10'd0)
          st_nxt = S_CMD2;
        else
        begin
          wr_ready  = !cyc_busy;
          cyc_start = !cyc_busy && wr_valid;
          cyc_kind  = CYC_WDAT;
          cyc_wdata = wr_data;
          if (cyc_done)
            dcnt_nxt = dcnt_r - 10'd1;
        end
      end
      S_CMD2:
      begin
        cyc_start = !cyc_busy;
        cyc_kind  = CYC_CMD;
        cyc_wdata = DW'(second_cmd(op_r));
        if (cyc_done)
        begin
          // marks the execute byte as sent for the wait state
          acnt_nxt = 2'd0;
          st_nxt   = S_BUSY0;
        end
      end
      S_BUSY0:
      begin
        // give the ready line time to fall through the synchroniser
        st_nxt = S_WAIT;
      end
      S_WAIT:
      begin
        if (rdy_s2_r)
        begin
          if (op_r == OP_READ)
            st_nxt = S_RDATA;
          else if (two_step && acnt_r == 2'd3)
            // copy-back execute waits out the source page load
            st_nxt = S_CMD2;
          else
          begin
            ce_nxt   = 1'b0;
            done_nxt = 1'b1;
            st_nxt   = S_IDLE;
          end
        end
      end
      S_RDATA:
      begin
        if (dcnt_r == 10'd0)
        begin
          ce_nxt   = 1'b0;
          done_nxt = 1'b1;
          st_nxt   = S_IDLE;
        end
        else
        begin
          cyc_start = !cyc_busy;
          cyc_kind  = CYC_RDAT;
          if (cyc_done)
          begin
            rdv_nxt  = 1'b1;
            dcnt_nxt = dcnt_r - 10'd1;
          end
        end
      end
    endcase
    // done and idle share one cycle; starting there would repeat the last cycle
    cyc_start = cyc_start && !cyc_done;
    wr_ready  = wr_ready && !cyc_done;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r   <= S_IDLE;
      op_r   <= OP_NONE;
      area_r <= AREA_FIRST;
      addr_r <= 24'h00_0000;
      acnt_r <= 2'd0;
      dcnt_r <= 10'd0;
      ce_r   <= 1'b0;
      done_r <= 1'b0;
      rdv_r  <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      op_r   <= op_nxt;
      area_r <= area_nxt;
      addr_r <= addr_nxt;
      acnt_r <= acnt_nxt;
      dcnt_r <= dcnt_nxt;
      ce_r   <= ce_nxt;
      done_r <= done_nxt;
      rdv_r  <= rdv_nxt;
    end
  end

  nand_bus_cycle #(.DW(DW)) u_cycle
  (
    .clk           (clk),
    .nrst          (nrst),
    .start         (cyc_start),
    .kind          (cyc_kind),
    .wdata         (cyc_wdata),
    .io_sync       (io_s2_r),
    .busy          (cyc_busy),
    .done          (cyc_done),
    .rdata         (cyc_rdata),
    .cle           (cle),
    .ale           (ale),
    .write_n       (write_n),
    .read_strobe_n (read_strobe_n),
    .io_out        (io_out),
    .io_oe_n       (io_oe_n)
  );

  assign req_ready    = (st_r == S_IDLE);
  assign chip_en_n    = !ce_r;
  assign op_done      = done_r;
  assign rd_valid     = rdv_r;
  assign rd_data      = cyc_rdata;
  assign spare_sel    = spare_skip;
  assign write_prot_n = 1'b1;
endmodule : nand_host

// ---- bench/nand_host_assertions.sv ----
// concurrent checks on the nand host pin side
`timescale 1ns/1ps
module nand_host_checker
#(
  parameter int DW = 16
)
(
  input wire logic          clk,           // clock
  input wire logic          nrst,          // reset, low
  input wire logic          chip_en_n,     // chip enable
  input wire logic          cle,           // command strobe
  input wire logic          ale,           // address strobe
  input wire logic          write_n,       // write strobe
  input wire logic          read_strobe_n, // read strobe
  input wire logic [DW-1:0] io_out,        // io drive
  input wire logic          io_oe_n,       // io enable
  input wire logic          ready_pin,     // ready line
  input wire logic          op_done,       // end pulse
  input wire logic          spare_skip,    // spare level in
  input wire logic          spare_sel      // spare pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // pin protocol
  // ------------------------------------------------------------
  a_strobe_excl: assert property (!(cle && ale))
    else $error("cle and ale high together");
  a_write_selects: assert property (!write_n |-> !chip_en_n && !io_oe_n)
    else $error("write strobe without select or drive");
  a_latch_steady: assert property ($rose(write_n) |-> $stable(cle) && $stable(ale))
    else $error("latch strobe moved at write edge");
  a_strobe_return: assert property ($fell(write_n) |-> ##[1:4] write_n)
    else $error("write strobe stuck low");
  a_upper_low: assert property ((cle || ale) && !io_oe_n |-> (io_out >> 8) == '0)
    else $error("upper io lines not low");
  a_cmd_legal: assert property ($fell(write_n) && cle |-> io_out[7:0] inside
    {8'h00, 8'h01, 8'h50, 8'h90, 8'hFF, 8'h70, 8'h80, 8'h10, 8'h8A, 8'h60, 8'hD0})
    else $error("undefined command code");
  a_read_released: assert property (!read_strobe_n |-> io_oe_n && !chip_en_n)
    else $error("host drives io during read");
  a_busy_quiet: assert property (!ready_pin [*3] ##1 $fell(write_n) |->
    cle && io_out[7:0] inside {8'hFF, 8'h70})
    else $error("cycle issued while device busy");
  a_done_ready: assert property (op_done |-> ready_pin && $past(ready_pin))
    else $error("done while device busy");
  a_spare_level: assert property (spare_sel == spare_skip)
    else $error("spare pin level wrong");
  cover property ($fell(write_n) && cle && io_out[7:0] == 8'h60);
  cover property (!ready_pin [*3] ##1 ready_pin);
  cover property (op_done);
endmodule : nand_host_checker
bind nand_host nand_host_checker #(.DW(DW)) u_nand_host_checker (.clk, .nrst, .chip_en_n,
  .cle, .ale, .write_n, .read_strobe_n, .io_out, .io_oe_n, .ready_pin, .op_done,
  .spare_skip, .spare_sel);

// ---- bench/nand_flash_model.sv ----
// behavioural nand flash device for the host bench
`timescale 1ns/1ps
module nand_flash_model
#(
  parameter int         DW      = 8,
  parameter int         BUSY_NS = 2000,
  parameter logic [7:0] ID0     = 8'hA5, // arbitrary id value
  parameter logic [7:0] ID1     = 8'h3C  // arbitrary id value
)
(
  input  wire logic          chip_en_n,     // chip enable, low
  input  wire logic          cle,           // command strobe
  input  wire logic          ale,           // address strobe
  input  wire logic          write_n,       // write strobe, low
  input  wire logic          read_strobe_n, // read strobe, low
  input  wire logic          spare_sel,     // high skips spare
  input  wire logic [DW-1:0] dq,            // io wire level
  output logic      [DW-1:0] dq_out,        // device io drive
  output logic               ready_pin      // ready, pulled up
);
  logic [DW+1:0] log_q [$];
  logic [7:0]    cmd  = 8'hFF;
  logic [7:0]    ad [3] = '{8'h00, 8'h00, 8'h00};
  logic          busy = 1'b0;
  logic          drv  = 1'b0;
  logic [DW-1:0] dout = '0;
  int            na = 0;
  int            col = 0;
  int            base = 0;
  event          go_busy;
  // ------------------------------------------------------------
  // device behaviour
  // ------------------------------------------------------------
  // released bus shows the inverse so stale data cannot pass
  assign dq_out    = (drv && !chip_en_n) ? dout : ~dout;
  assign ready_pin = !busy;
  always @(go_busy)
  begin
    busy = 1'b1;
    #(BUSY_NS);
    busy = 1'b0;
  end
  always @(posedge write_n)
  begin
    drv = 1'b0;
    if (!chip_en_n) log_q.push_back({cle, ale, dq});
    if (!chip_en_n && cle && !(busy && !(dq[7:0] inside {8'hFF, 8'h70})))
    begin
      cmd  = dq[7:0];
      na   = 0;
      base = (cmd == 8'h50) ? ((DW == 8) ? 512 : 256) : 0;
      if (cmd == 8'h01 && DW == 8) base = 256;
      if (cmd inside {8'h10, 8'h8A, 8'hD0, 8'hFF}) -> go_busy;
    end
    else if (!chip_en_n && ale && !busy)
    begin
      if (na < ((cmd == 8'h60) ? 2 : 3)) ad[na + ((cmd == 8'h60) ? 1 : 0)] = dq[7:0];
      na++;
      if (na == 1) col = base + ad[0];
      if (na == 3 && cmd inside {8'h00, 8'h01, 8'h50}) -> go_busy;
    end
  end
  always @(negedge read_strobe_n)
  begin
    if (spare_sel && col == ((DW == 8) ? 512 : 256)) col = 0;
    if (cmd == 8'h70) dout = DW'({1'b1, !busy, 6'h00});
    else if (cmd == 8'h90) dout = DW'((col == 0) ? ID0 : ID1);
    else dout = DW'(col + ad[1]);
    drv = !chip_en_n;
    col++;
  end
endmodule : nand_flash_model

// ---- bench/nand_host_bench.sv ----
// self-checking bench for the nand host controller
`timescale 1ns/1ps
module nand_host_bench;
  import nand_host_pkg::*;
  localparam int         DW   = 8;
  localparam logic [7:0] ID_A = 8'hA5; // arbitrary
  localparam logic [7:0] ID_B = 8'h3C; // arbitrary
  typedef logic [DW+1:0] ent_t;
  logic          clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, wr_valid = 1'b0;
  logic          spare_skip = 1'b0;
  op_t           req_op = OP_NONE;
  area_t         req_area = AREA_FIRST;
  logic [23:0]   req_addr = '0;
  logic [9:0]    req_len = '0;
  logic [DW-1:0] wr_data = '0;
  logic          req_ready, wr_ready, rd_valid, op_done, spare_sel, chip_en_n;
  logic          cle, ale, write_n, read_strobe_n, write_prot_n, io_oe_n, ready_pin;
  logic [DW-1:0] rd_data, io_out, dq_out, rd_q [$];
  wire  [DW-1:0] io_wire = !io_oe_n ? io_out : dq_out;
  logic          saw_busy;
  int            n_errors = 0, check_count = 0;
  nand_host #(.DW(DW), .NWORDS(528)) u_nand_host (.clk, .nrst, .req_valid, .req_ready,
    .req_op, .req_area, .req_addr, .req_len, .wr_valid, .wr_ready, .wr_data, .rd_valid,
    .rd_data, .op_done, .spare_skip, .spare_sel, .chip_en_n, .cle, .ale, .write_n,
    .read_strobe_n, .write_prot_n, .io_in(io_wire), .io_out, .io_oe_n, .ready_pin);
  nand_flash_model #(.DW(DW), .ID0(ID_A), .ID1(ID_B)) u_nand_flash_model (.chip_en_n,
    .cle, .ale, .write_n, .read_strobe_n, .spare_sel, .dq(io_wire), .dq_out, .ready_pin);
  initial
  begin
    forever #50 clk = ~clk;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input ent_t got, input ent_t exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic check_log(input ent_t exp [$]);
    check(ent_t'(u_nand_flash_model.log_q.size()), ent_t'(exp.size()), "cycle count");
    foreach (exp[j])
      if (j < u_nand_flash_model.log_q.size())
        check(u_nand_flash_model.log_q[j], exp[j], "bus cycle");
  endtask : check_log
  task automatic run(input op_t op, input area_t ar, input logic [23:0] a, input int len);
    int   i;
    int   k;
    logic took;
    i = 0;
    took = 1'b0;
    saw_busy = 1'b0;
    rd_q.delete();
    u_nand_flash_model.log_q.delete();
    @(negedge clk);
    req_op = op;
    req_area = ar;
    req_addr = a;
    req_len = 10'(len);
    req_valid = 1'b1;
    wr_valid = (op == OP_PROGRAM);
    wr_data = 8'h5A;
    for (k = 0; k < 3000; k++)
    begin
      @(negedge clk);
      if (!req_ready) req_valid = 1'b0;
      if (took)
      begin
        i++;
        wr_data = 8'(8'h5A + i);
        if (i == len) wr_valid = 1'b0;
      end
      took = wr_valid && wr_ready;
      if (!ready_pin) saw_busy = 1'b1;
      if (rd_valid) rd_q.push_back(rd_data);
      if (op_done) break;
    end
    if (k == 3000) check(1, 0, "no completion");
  endtask : run
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_read();
    area_t ar [3] = '{AREA_FIRST, AREA_SECOND, AREA_SPARE};
    int    bs [3] = '{0, 256, 512};
    ent_t  cd [3] = '{10'h200, 10'h201, 10'h250};
    foreach (ar[m])
    begin
      run(OP_READ, ar[m], 24'h12_3404, 3);
      check_log({cd[m], 10'h104, 10'h134, 10'h112});
      check(ent_t'(saw_busy), 1, "read busy");
      check(ent_t'(rd_q.size()), 3, "read count");
      foreach (rd_q[j])
        check(ent_t'(rd_q[j]), ent_t'(8'(bs[m] + 4 + j + 8'h34)), "read data");
    end
    $display("test read done");
  endtask : t_read
  task automatic t_skip();
    int ex [4] = '{510, 511, 0, 1};
    spare_skip = 1'b1;
    run(OP_READ, AREA_SECOND, 24'h00_05FE, 4);
    check(ent_t'(spare_sel), 1, "spare pin");
    foreach (ex[j])
      check(ent_t'(rd_q[j]), ent_t'(8'(ex[j] + 5)), "skip data");
    spare_skip = 1'b0;
    $display("test skip done");
  endtask : t_skip
  task automatic t_program();
    run(OP_PROGRAM, AREA_FIRST, 24'h00_0120, 4);
    check_log({10'h280, 10'h120, 10'h101, 10'h100, 10'h05A, 10'h05B,
      10'h05C, 10'h05D, 10'h210});
    check(ent_t'(saw_busy), 1, "program busy");
    $display("test program done");
  endtask : t_program
  task automatic t_erase_copy();
    run(OP_ERASE, AREA_FIRST, 24'h07_FF00, 0);
    check_log({10'h260, 10'h1FF, 10'h107, 10'h2D0});
    check(ent_t'(saw_busy), 1, "erase busy");
    run(OP_COPY, AREA_FIRST, 24'h03_0210, 0);
    check_log({10'h200, 10'h110, 10'h102, 10'h103, 10'h28A});
    check(ent_t'(saw_busy), 1, "copy busy");
    $display("test erase copy done");
  endtask : t_erase_copy
  task automatic t_single();
    run(OP_IDENTIFICATION_READ_CMD, AREA_FIRST, 24'h00_0000, 2);
    check_log({10'h290, 10'h100});
    check(ent_t'(rd_q[0]), ent_t'(ID_A), "id first");
    check(ent_t'(rd_q[1]), ent_t'(ID_B), "id second");
    run(OP_STATUS, AREA_FIRST, 24'h00_0000, 1);
    check_log({10'h270});
    check(ent_t'(rd_q[0]), ent_t'(8'hC0), "status");
    run(OP_RESET, AREA_FIRST, 24'h00_0000, 0);
    check_log({10'h2FF});
    check(ent_t'(saw_busy), 1, "reset busy");
    check(ent_t'(write_prot_n), 1, "write protect released");
    $display("test single done");
  endtask : t_single
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial
  begin
    #2000000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_read();
    t_skip();
    t_program();
    t_erase_copy();
    t_single();
    results();
  end
endmodule : nand_host_bench
